// file: hw/flash_cmd_seq.sv
// Serial flash command sequencer: chip erase, id reads, security registers, soft reset.
// Assumes the host serial clock stands still while select is high and that the
// neighbouring array, status and mode logic run on clk_sys.
//
// Functional notes
// - Chip erase: 60H or C7H, latch set
// - Chip erase only if select rises after bit 8
// - Chip erase self-timed, busy set, latch cleared
// - Chip erase only with no sector protected
// - 90H plus zero address returns maker, part
// - 9FH returns maker, type, capacity bytes
// - 9FH not decoded while busy
// - Select rise ends id output, standby
// - 4BH, address, dummy, then 128-bit number
// - Two 1024-byte registers, fixed address layout
// - 44H erase needs exact 32-bit frame
// - Register erase self-timed, busy, latch cleared
// - Locked register ignores erase and program
// - 42H program, address, data bytes, four pages
// - Register program self-timed, busy, latch cleared
// - 48H read, address, dummy, data out
// - Read address wraps within 1024 bytes
// - Reset needs 66H frame then 99H frame
// - Reset aborts work, clears volatile state
// - Only reads answered during reset recovery
`default_nettype none
module flash_cmd_seq
    import flash_seq_pkg::*;
#(
    parameter int unsigned CE_TIME_US = 20000,
    parameter int unsigned SE_TIME_US = 40000,
    parameter int unsigned PP_TIME_US = 600,
    parameter int unsigned RST_E_TIME_US = 12000,
    parameter logic [7:0] MAKER_CODE = 8'h5a,      // Arbitrary value
    parameter logic [7:0] PART_CODE = 8'h12,       // Arbitrary value
    parameter logic [7:0] MEM_TYPE = 8'h34,        // Arbitrary value
    parameter logic [7:0] CAPACITY = 8'h56,        // Arbitrary value
    parameter logic [127:0] UNIQUE_NUM = 128'h0123456789abcdef0011223344556677 // Arbitrary
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic si,
    output logic so,
    output logic so_oe_n,
    input wire logic [2:0] protect_level_bits,
    input wire logic protect_complement,
    input wire logic [1:0] otp_lock_bits,
    input wire logic suspend_flag,
    input wire logic deep_pd_flag,
    output logic write_busy_flag,
    output logic write_latch_flag,
    output logic chip_erase_go,
    output logic soft_reset_go,
    output logic reset_recovering
);
    localparam logic [TIMER_W-1:0] CE_CYC = TIMER_W'(CE_TIME_US * 1000 / SYS_CLK_NS);
    localparam logic [TIMER_W-1:0] SE_CYC = TIMER_W'(SE_TIME_US * 1000 / SYS_CLK_NS);
    localparam logic [TIMER_W-1:0] PP_CYC = TIMER_W'(PP_TIME_US * 1000 / SYS_CLK_NS);
    localparam logic [TIMER_W-1:0] RSTE_CYC = TIMER_W'(RST_E_TIME_US * 1000 / SYS_CLK_NS);
    localparam logic [TIMER_W-1:0] RSTN_CYC = TIMER_W'(RST_CYC);

    // Non-volatile content: not reset, survives power cycles in the real part
    logic [7:0] otp_mem [2*OTP_BYTES];
    logic [7:0] pbuf [PAGE_BYTES];

    // ========================================================================
    // Link side: shift-in on rising serial clock
    logic frame_start_ff;
    logic [15:0] cnt_ff, nxt_cnt, cur_cnt;
    logic [7:0] sh_ff, nxt_sh, cmd_ff, nxt_cmd;
    logic [23:0] addr_ff, nxt_addr;
    logic [PAGE_BYTES-1:0] mask_ff, nxt_mask;
    logic busy_meta_ff, busy_s_ff, wel_meta_ff, wel_s_ff;
    logic pb_we;
    logic [7:0] pb_wa;
    logic [15:0] pb_idx;
    logic write_busy_ff, write_latch_ff;

    // Select high marks the next rising edge as the first of a frame
    always_ff @(posedge sclk or posedge cs_n) begin
        if (cs_n) begin
            frame_start_ff <= 1'b1;
        end else if (clk_en) begin
            frame_start_ff <= 1'b0;
        end
    end

    always_comb begin
        cur_cnt = frame_start_ff ? 16'h0000 : cnt_ff;
        nxt_cnt = (cur_cnt == LEN_SAT) ? cur_cnt : cur_cnt + 16'h0001;
        nxt_sh = {sh_ff[6:0], si};
        nxt_cmd = cmd_ff;
        nxt_addr = addr_ff;
        nxt_mask = mask_ff;
        pb_idx = (cur_cnt - (LEN_DUMMY - 16'h0001)) >> 3;
        pb_wa = addr_ff[7:0] + pb_idx[7:0];
        pb_we = 1'b0;
        if (cur_cnt == LEN_OP - 16'h0001) begin
            nxt_cmd = nxt_sh;
        end
        // Address and page mask feed the running walk; frames during a cycle leave them alone
        if (cur_cnt == LEN_OP - 16'h0001 && !busy_s_ff) begin
            nxt_mask = '0;
        end
        if (cur_cnt >= LEN_OP && cur_cnt < LEN_ADDR && !busy_s_ff) begin
            nxt_addr = {addr_ff[22:0], si};
        end
        // Data bytes wrap inside the addressed page; the last 256 win
        if (cmd_ff == OP_SR_PROG && !busy_s_ff && cur_cnt >= LEN_DUMMY - 16'h0001
                && cur_cnt[2:0] == 3'h7) begin
            pb_we = 1'b1;
            nxt_mask[pb_wa] = 1'b1;
        end
    end

    always_ff @(posedge sclk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_ff <= 16'h0000;
            sh_ff <= 8'h00;
            cmd_ff <= 8'h00;
            addr_ff <= 24'h000000;
            mask_ff <= '0;
            busy_meta_ff <= 1'b0;
            busy_s_ff <= 1'b0;
            wel_meta_ff <= 1'b0;
            wel_s_ff <= 1'b0;
        end else if (clk_en) begin
            cnt_ff <= nxt_cnt;
            sh_ff <= nxt_sh;
            cmd_ff <= nxt_cmd;
            addr_ff <= nxt_addr;
            mask_ff <= nxt_mask;
            busy_meta_ff <= write_busy_ff;
            busy_s_ff <= busy_meta_ff;
            wel_meta_ff <= write_latch_ff;
            wel_s_ff <= wel_meta_ff;
        end
    end

    always_ff @(posedge sclk) begin
        if (clk_en && pb_we) begin
            pbuf[pb_wa] <= nxt_sh;
        end
    end

    // ========================================================================
    // Link side: shift-out on falling serial clock
    logic [15:0] hdr, oidx;
    logic [9:0] rd_off;
    logic [7:0] obyte;
    logic oact, nxt_so, nxt_oe_n;
    logic so_ff, so_oe_n_ff;

    always_comb begin
        hdr = LEN_SAT;
        obyte = 8'h00;
        case (cmd_ff)
            OP_STAT: hdr = LEN_OP;
            OP_ID3: hdr = LEN_OP;
            OP_MPID: hdr = LEN_ADDR;
            OP_UID: hdr = LEN_DUMMY;
            OP_SR_READ: hdr = LEN_DUMMY;
            default: hdr = LEN_SAT;
        endcase
        oidx = (cnt_ff - hdr) >> 3;
        rd_off = addr_ff[9:0] + oidx[9:0];  // Wraps 3FFH to 000H
        case (cmd_ff)
            OP_STAT: obyte = {6'h00, wel_s_ff, busy_s_ff};
            OP_ID3: begin
                case (oidx % 16'h0003)
                    16'h0000: obyte = MAKER_CODE;
                    16'h0001: obyte = MEM_TYPE;
                    default: obyte = CAPACITY;
                endcase
            end
            OP_MPID: obyte = oidx[0] ? PART_CODE : MAKER_CODE;
            OP_UID: obyte = UNIQUE_NUM[8'(8'd127 - {oidx[3:0], 3'h0}) -: 8];
            OP_SR_READ: begin
                // Byte select from A12 and A9-0
                obyte = sr_addr_ok(addr_ff) ? otp_mem[{addr_ff[12], rd_off}] : ERASED_BYTE;
            end
            default: obyte = 8'h00;
        endcase
        // Only status reads are decoded while a cycle runs
        oact = !frame_start_ff && cnt_ff >= hdr && (cmd_ff == OP_STAT || !busy_s_ff);
        nxt_so = oact ? obyte[3'h7 - cnt_ff[2:0] + hdr[2:0]] : 1'b0;
        nxt_oe_n = !oact;
    end

    // Select high releases the output at once and ends the read
    always_ff @(negedge sclk or posedge cs_n or negedge rst_n) begin
        if (!rst_n || cs_n) begin
            so_ff <= 1'b0;
            so_oe_n_ff <= 1'b1;
        end else if (clk_en) begin
            so_ff <= nxt_so;
            so_oe_n_ff <= nxt_oe_n;
        end
    end

    assign so = so_ff;
    assign so_oe_n = so_oe_n_ff;

    // ========================================================================
    // System side: frame end detection
    // The link registers are quiet once select is high, so they are read
    // only after the synchronised rising edge of select.
    logic cs_meta_ff, cs_sync_ff, cs_prev_ff, cs_rise;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cs_meta_ff <= 1'b1;
            cs_sync_ff <= 1'b1;
            cs_prev_ff <= 1'b1;
        end else if (clk_en) begin
            cs_meta_ff <= cs_n;
            cs_sync_ff <= cs_meta_ff;
            cs_prev_ff <= cs_sync_ff;
        end
    end

    assign cs_rise = cs_sync_ff && !cs_prev_ff;

    // ========================================================================
    // System side: command execution and self-timed cycles
    seq_state_type state_ff, nxt_state;
    op_kind_type op_ff, nxt_op;
    logic [TIMER_W-1:0] timer_ff, nxt_timer;
    logic [10:0] walk_ff, nxt_walk;
    logic nxt_busy, nxt_wel, armed_ff, nxt_armed;
    logic ce_go_ff, nxt_ce_go, srst_ff, nxt_srst;
    logic prot_ok, lock_hit, len8, wr_ok, rst_ok;
    logic mem_we;
    logic [10:0] mem_wa;
    logic [7:0] mem_wd;

    always_comb begin
        // No sector protected: all three bits clear or set, matched by complement
        prot_ok = (protect_level_bits == 3'b000 && !protect_complement)
            || (protect_level_bits == 3'b111 && protect_complement);
        lock_hit = otp_lock_bits[addr_ff[12]];
        len8 = cnt_ff == LEN_OP;
        wr_ok = write_latch_ff && !suspend_flag && !deep_pd_flag;
        rst_ok = cs_rise && len8 && cmd_ff == OP_RST && armed_ff;
        nxt_state = state_ff;
        nxt_op = op_ff;
        nxt_timer = timer_ff;
        nxt_walk = walk_ff;
        nxt_busy = write_busy_ff;
        nxt_wel = write_latch_ff;
        nxt_armed = armed_ff;
        nxt_ce_go = 1'b0;
        nxt_srst = 1'b0;
        mem_we = 1'b0;
        mem_wa = 11'h000;
        mem_wd = ERASED_BYTE;
        if (cs_rise) begin
            // Enable only counts for the very next frame
            nxt_armed = len8 && cmd_ff == OP_RST_EN && state_ff != ST_RECOVER;
        end
        case (state_ff)
            ST_IDLE: begin
                if (rst_ok) begin
                    nxt_state = ST_RECOVER;
                    nxt_timer = RSTN_CYC;
                    nxt_wel = 1'b0;
                    nxt_srst = 1'b1;
                end else if (cs_rise && !deep_pd_flag) begin
                    if (len8 && cmd_ff == OP_WL_SET) begin
                        nxt_wel = 1'b1;
                    end else if (len8 && cmd_ff == OP_WL_CLR) begin
                        nxt_wel = 1'b0;
                    end else if (len8 && (cmd_ff == OP_CE_A || cmd_ff == OP_CE_B)
                            && wr_ok && prot_ok) begin
                        // Exact 8-bit frame, latch set, unprotected
                        nxt_state = ST_BUSY;
                        nxt_op = OPK_CHIP;
                        nxt_timer = CE_CYC;
                        nxt_busy = 1'b1;
                        nxt_wel = 1'b0;
                        nxt_ce_go = 1'b1;
                    end else if (cnt_ff == LEN_ADDR && cmd_ff == OP_SR_ERASE && wr_ok
                            && sr_addr_ok(addr_ff) && !lock_hit) begin
                        nxt_state = ST_BUSY;
                        nxt_op = OPK_SRE;
                        nxt_timer = SE_CYC;
                        nxt_busy = 1'b1;
                        nxt_wel = 1'b0;
                        nxt_walk = 11'h000;
                    end else if (cmd_ff == OP_SR_PROG && cnt_ff >= LEN_DUMMY
                            && cnt_ff[2:0] == 3'h0 && wr_ok
                            && sr_addr_ok(addr_ff) && !lock_hit) begin
                        nxt_state = ST_BUSY;
                        nxt_op = OPK_SRP;
                        nxt_timer = PP_CYC;
                        nxt_busy = 1'b1;
                        nxt_wel = 1'b0;
                        nxt_walk = 11'h000;
                    end
                end
            end
            ST_BUSY: begin
                nxt_timer = timer_ff - TIMER_W'(1);
                // One byte per cycle; both walks finish well inside their cycle time
                if (op_ff == OPK_SRE && walk_ff != ERASE_WALK_END) begin
                    mem_we = 1'b1;
                    mem_wa = {addr_ff[12], walk_ff[9:0]};
                    nxt_walk = walk_ff + 11'h001;
                end else if (op_ff == OPK_SRP && walk_ff != PROG_WALK_END) begin
                    mem_we = mask_ff[walk_ff[7:0]];
                    mem_wa = {addr_ff[12], addr_ff[9:8], walk_ff[7:0]};
                    // Programming can only clear bits
                    mem_wd = otp_mem[mem_wa] & pbuf[walk_ff[7:0]];
                    nxt_walk = walk_ff + 11'h001;
                end
                if (rst_ok) begin
                    // Abort: longer recovery if an erase was running
                    nxt_state = ST_RECOVER;
                    nxt_timer = (op_ff == OPK_SRP) ? RSTN_CYC : RSTE_CYC;
                    nxt_busy = 1'b0;
                    nxt_wel = 1'b0;
                    nxt_srst = 1'b1;
                    nxt_op = OPK_NONE;
                end else if (timer_ff <= TIMER_W'(1)) begin
                    nxt_state = ST_IDLE;
                    nxt_busy = 1'b0;
                    nxt_op = OPK_NONE;
                end
            end
            ST_RECOVER: begin
                nxt_timer = timer_ff - TIMER_W'(1);
                nxt_armed = 1'b0;
                if (timer_ff <= TIMER_W'(1)) begin
                    nxt_state = ST_IDLE;
                end
            end
            default: begin
                nxt_state = ST_IDLE;
                nxt_busy = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= ST_IDLE;
            op_ff <= OPK_NONE;
            timer_ff <= '0;
            walk_ff <= 11'h000;
            write_busy_ff <= 1'b0;
            write_latch_ff <= 1'b0;
            armed_ff <= 1'b0;
            ce_go_ff <= 1'b0;
            srst_ff <= 1'b0;
        end else if (clk_en) begin
            state_ff <= nxt_state;
            op_ff <= nxt_op;
            timer_ff <= nxt_timer;
            walk_ff <= nxt_walk;
            write_busy_ff <= nxt_busy;
            write_latch_ff <= nxt_wel;
            armed_ff <= nxt_armed;
            ce_go_ff <= nxt_ce_go;
            srst_ff <= nxt_srst;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (clk_en && mem_we) begin
            otp_mem[mem_wa] <= mem_wd;
        end
    end

    assign write_busy_flag = write_busy_ff;
    assign write_latch_flag = write_latch_ff;
    assign chip_erase_go = ce_go_ff;
    assign soft_reset_go = srst_ff;
    assign reset_recovering = (state_ff == ST_RECOVER);

    // ========================================================================
    // Checks
    sequence s_ce_frame;
        cs_rise && state_ff == ST_IDLE && !rst_ok && !deep_pd_flag
            && (cmd_ff == OP_CE_A || cmd_ff == OP_CE_B);
    endsequence

    sequence s_ce_good;
        s_ce_frame ##0 (len8 && write_latch_ff && prot_ok && !suspend_flag);
    endsequence

    chk_ce_needs_latch: assert property (@(posedge clk_sys) disable iff (!rst_n)
        clk_en throughout (s_ce_frame ##0 !write_latch_ff) |=> !write_busy_flag)
        else $error("chip erase started without write latch");
    chk_ce_exact_len: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (s_ce_frame ##0 !len8) |=> (state_ff == ST_IDLE))
        else $error("chip erase accepted with wrong frame length");
    chk_ce_start: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (s_ce_good ##0 clk_en) |=> (write_busy_flag && !write_latch_flag && chip_erase_go)
            ##1 (!chip_erase_go && write_busy_flag))
        else $error("chip erase did not start correctly");
    chk_ce_protect: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (s_ce_frame ##0 !prot_ok) |=> !chip_erase_go)
        else $error("chip erase ran with protected sectors");
    chk_otp_locked: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (cs_rise && state_ff == ST_IDLE && lock_hit
            && (cmd_ff == OP_SR_ERASE || cmd_ff == OP_SR_PROG)) |=> !write_busy_flag)
        else $error("locked security register was altered");
    chk_busy_holds: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (clk_en && state_ff == ST_BUSY && timer_ff > TIMER_W'(1) && !rst_ok)
            |=> write_busy_flag && $stable(op_ff))
        else $error("busy dropped before the cycle time");
    chk_reset_recover: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (clk_en && rst_ok && state_ff != ST_RECOVER) |=> reset_recovering && soft_reset_go
            && !write_latch_flag && !write_busy_flag)
        else $error("accepted reset did not enter recovery");
    chk_recover_quiet: assert property (@(posedge clk_sys) disable iff (!rst_n)
        reset_recovering |=> !write_busy_flag && !chip_erase_go)
        else $error("command accepted during reset recovery");
    chk_id_when_busy: assert property (@(negedge sclk) disable iff (!rst_n || cs_n)
        (cmd_ff == OP_ID3 && busy_s_ff && !frame_start_ff) |=> so_oe_n)
        else $error("id read decoded during a busy cycle");
endmodule // flash_cmd_seq
`default_nettype wire

// file: hw/flash_seq_pkg.sv
// Constants, command codes and state types for the serial flash sequencer.
// Assumes a 25 MHz system clock; serial timing comes from the host clock.
`default_nettype none
package flash_seq_pkg;
    // ========================================================================
    // Clock and timing
    localparam int unsigned SYS_CLK_NS = 40;
    localparam int unsigned T_RST_US = 30;
    localparam int unsigned RST_CYC = (T_RST_US * 1000 + SYS_CLK_NS - 1) / SYS_CLK_NS;
    localparam int unsigned TIMER_W = 32;
    // ========================================================================
    // Command codes
    localparam logic [7:0] OP_CE_A = 8'h60;
    localparam logic [7:0] OP_CE_B = 8'hc7;
    localparam logic [7:0] OP_MPID = 8'h90;
    localparam logic [7:0] OP_ID3 = 8'h9f;
    localparam logic [7:0] OP_UID = 8'h4b;
    localparam logic [7:0] OP_SR_ERASE = 8'h44;
    localparam logic [7:0] OP_SR_PROG = 8'h42;
    localparam logic [7:0] OP_SR_READ = 8'h48;
    localparam logic [7:0] OP_RST_EN = 8'h66;
    localparam logic [7:0] OP_RST = 8'h99;
    localparam logic [7:0] OP_WL_SET = 8'h06;
    localparam logic [7:0] OP_WL_CLR = 8'h04;
    localparam logic [7:0] OP_STAT = 8'h05;
    // ========================================================================
    // Frame lengths in bits
    localparam logic [15:0] LEN_OP = 16'h0008;
    localparam logic [15:0] LEN_ADDR = 16'h0020;
    localparam logic [15:0] LEN_DUMMY = 16'h0028;
    localparam logic [15:0] LEN_SAT = 16'hffff;
    // ========================================================================
    // Security register geometry
    localparam int unsigned OTP_BYTES = 1024;
    localparam int unsigned PAGE_BYTES = 256;
    localparam logic [10:0] ERASE_WALK_END = 11'h400;
    localparam logic [10:0] PROG_WALK_END = 11'h100;
    localparam logic [7:0] ERASED_BYTE = 8'hff;
    // ========================================================================
    // Types
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_BUSY = 2'b01,
        ST_RECOVER = 2'b11
    } seq_state_type;
    typedef enum logic [1:0] {
        OPK_NONE = 2'b00,
        OPK_CHIP = 2'b01,
        OPK_SRE = 2'b10,
        OPK_SRP = 2'b11
    } op_kind_type;

    // Security register address check: A23-16, A15-13 and A11-10 all zero
    function automatic logic sr_addr_ok(input logic [23:0] a);
        sr_addr_ok = (a[23:13] == 11'h000) && (a[11:10] == 2'b00);
    endfunction
endpackage
`default_nettype wire

// file: tb/flash_host_model.sv
// Host serial controller model: drives select, serial clock and serial input.
// Assumes one caller at a time; the serial clock stands still between frames.
`default_nettype none
module flash_host_model (
    output logic sclk,
    output logic cs_n,
    output logic si,
    input wire logic so,
    input wire logic so_oe_n
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] rx_q[$];
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        si = 1'b0;
    end
    // ========================================
    // One bit, sampled back at the rising edge; undriven output reads unknown
    task automatic clk_bit(input logic v, output logic s);
        si = v;
        #40 sclk = 1'b1;
        s = so_oe_n ? 1'bx : so;
        #40 sclk = 1'b0;
    endtask
    // ========================================
    // Frame: bytes MSB first, extra bits, read bytes; select low throughout
    task automatic xfer(input logic [7:0] tx[$], input int xb, input int nrd);
        logic [7:0] b;
        logic s;
        rx_q.delete();
        #7 cs_n = 1'b0;
        foreach (tx[i]) for (int k = 7; k >= 0; k--) clk_bit(tx[i][k], s);
        repeat (xb) clk_bit(1'b0, s);
        repeat (nrd) begin
            for (int k = 7; k >= 0; k--) clk_bit(~si, b[k]);
            rx_q.push_back(b);
        end
        // Select rises right after the last bit; gap well over four system cycles
        #40 cs_n = 1'b1;
        si = ~si;
        #400;
    endtask
endmodule // flash_host_model
`default_nettype wire

// file: tb/serial_flash_erase_id_otp_reset_tb.sv
// Bench for the flash command sequencer with an integer model of the security registers.
// Assumes short self-timed parameters so the run stays well under a millisecond.
`default_nettype none
module serial_flash_erase_id_otp_reset_tb
    import flash_seq_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [127:0] UID = 128'hc3d2e1f00f1e2d3c4b5a69788796a5b4; // Arbitrary
    localparam logic [7:0] IDB[3] = '{8'h3c, 8'h71, 8'h15}; // Arbitrary codes
    localparam logic [7:0] PART = 8'h2e; // Arbitrary
    logic clk_sys = 1'b0, rst_n = 1'b0, sclk, cs_n, si, so, so_oe_n;
    logic [2:0] protect_level_bits = 3'h0;
    logic protect_complement = 1'b0;
    logic suspend_flag = 1'b0, deep_pd_flag = 1'b0;
    logic [1:0] otp_lock_bits = 2'h0;
    logic write_busy_flag, write_latch_flag, chip_erase_go, soft_reset_go, reset_recovering;
    int failures = 0, num_checks = 0, n_ce = 0, n_rst = 0;
    int mem[1024];
    always #20 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        n_ce += int'(chip_erase_go === 1'b1);
        n_rst += int'(soft_reset_go === 1'b1);
    end
    flash_cmd_seq #(.CE_TIME_US(50), .SE_TIME_US(50), .PP_TIME_US(20), .RST_E_TIME_US(5),
        .MAKER_CODE(IDB[0]), .PART_CODE(PART), .MEM_TYPE(IDB[1]), .CAPACITY(IDB[2]),
        .UNIQUE_NUM(UID)) DUT (.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(1'b1), .sclk(sclk),
        .cs_n(cs_n), .si(si), .so(so), .so_oe_n(so_oe_n),
        .protect_level_bits(protect_level_bits), .protect_complement(protect_complement),
        .otp_lock_bits(otp_lock_bits), .suspend_flag(suspend_flag),
        .deep_pd_flag(deep_pd_flag),
        .write_busy_flag(write_busy_flag), .write_latch_flag(write_latch_flag),
        .chip_erase_go(chip_erase_go), .soft_reset_go(soft_reset_go),
        .reset_recovering(reset_recovering));
    flash_host_model h (.sclk(sclk), .cs_n(cs_n), .si(si), .so(so), .so_oe_n(so_oe_n));
    // ========================================
    // Checking and closing
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic st(input logic l, input logic b);
        h.xfer('{OP_STAT}, 0, 1);
        check("status", h.rx_q[0], {6'h00, l, b});
    endtask
    // Busy must follow the decision; id reads stay silent while busy
    task automatic settle(input logic b);
        repeat (8) @(posedge clk_sys);
        check("busy", {7'h00, write_busy_flag}, {7'h00, b});
        if (b) begin
            h.xfer('{OP_ID3}, 0, 1);
            check("id_busy", h.rx_q[0], 8'hxx);
            st(1'b0, 1'b1);
        end
        for (int n = 0; n < 3000 && write_busy_flag !== 1'b0; n++) @(posedge clk_sys);
        check("done", {6'h00, write_busy_flag, write_latch_flag}, {7'h00, ~b});
    endtask
    // ========================================
    // Main sequence
    initial begin
        void'($urandom(32'ha737));
        repeat (12) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk_sys);
        st(1'b0, 1'b0);
        h.xfer('{OP_ID3}, 0, 4);
        for (int i = 0; i < 4; i++) check("id3", h.rx_q[i], IDB[i % 3]);
        check("oe_end", {7'h00, so_oe_n}, 8'h01);
        h.xfer('{OP_MPID, 8'h00, 8'h00, 8'h00}, 0, 2);
        check("maker", h.rx_q[0], IDB[0]);
        check("part", h.rx_q[1], PART);
        h.xfer('{OP_UID, 8'h00, 8'h00, 8'h00, 8'h00}, 0, 16);
        for (int i = 0; i < 16; i++) check("uid", h.rx_q[i], UID[127 - 8 * i -: 8]);
        // Protection table, both opcodes, and one frame with a ninth bit
        for (int i = 0; i < 5; i++) begin
            @(posedge clk_sys);
            protect_level_bits <= (i < 2) ? 3'h0 : 3'h7;
            protect_complement <= i[0] | (i == 4);
            h.xfer('{OP_WL_SET}, 0, 0);
            h.xfer('{i[1] ? OP_CE_B : OP_CE_A}, int'(i == 4), 0);
            settle(i == 0 || i == 3);
        end
        // Refusals: suspended, powered down, then latch cleared first
        for (int i = 0; i < 3; i++) begin
            @(posedge clk_sys);
            suspend_flag <= (i == 0);
            deep_pd_flag <= (i == 1); // No id read while powered down
            h.xfer('{(i == 2) ? OP_WL_CLR : OP_WL_SET}, 0, 0);
            h.xfer('{OP_CE_A}, 0, 0);
            repeat (8) @(posedge clk_sys);
            check("ce_refused", {6'h00, write_busy_flag, write_latch_flag}, {7'h00, i != 2});
        end
        @(posedge clk_sys);
        otp_lock_bits <= 2'b10;
        foreach (mem[k]) mem[k] = 'hff;
        // Register 0 open, register 1 locked, then a bad address
        for (int r = 0; r < 3; r++) begin
            logic [23:0] a;
            logic [7:0] d[$];
            a = (r == 0) ? 24'h0003fe : (r == 1) ? 24'h0013fe : 24'h000bfe;
            h.xfer('{OP_WL_SET}, 0, 0);
            h.xfer('{OP_SR_ERASE, a[23:16], a[15:8], a[7:0]}, 0, 0);
            settle(r == 0);
            d = '{OP_SR_PROG, a[23:16], a[15:8], a[7:0]};
            for (int j = 0; j < 4; j++) begin
                d.push_back(8'($urandom));
                if (r == 0) mem[(a & 'h300) | ((a + j) & 'hff)] &= d[4 + j];
            end
            h.xfer('{OP_WL_SET}, 0, 0);
            h.xfer(d, 0, 0);
            settle(r == 0);
        end
        for (int s = 0; s < 2; s++) begin
            logic [9:0] a;
            a = s ? 10'h2ff : 10'h3fe;
            h.xfer('{OP_SR_READ, 8'h00, {6'h00, a[9:8]}, a[7:0], 8'h00}, 0, 4);
            for (int j = 0; j < 4; j++) check("sr_rd", h.rx_q[j], 8'(mem[(a + j) % 1024]));
        end
        // Reset: an intervening frame spoils the pair; a clean pair aborts the erase
        h.xfer('{OP_WL_SET}, 0, 0);
        h.xfer('{OP_CE_A}, 0, 0);
        st(1'b0, 1'b1);
        h.xfer('{OP_RST_EN}, 0, 0);
        h.xfer('{OP_STAT}, 0, 1);
        h.xfer('{OP_RST}, 0, 0);
        check("rst_skip", 8'(n_rst), 8'h00);
        h.xfer('{OP_RST_EN}, 0, 0);
        h.xfer('{OP_RST}, 0, 0);
        repeat (8) @(posedge clk_sys);
        check("rst", {5'h00, reset_recovering, write_busy_flag, write_latch_flag}, 8'h04);
        h.xfer('{OP_WL_SET}, 0, 0);
        for (int n = 0; n < 2000 && reset_recovering !== 1'b0; n++) @(posedge clk_sys);
        check("wl_refused", {7'h00, write_latch_flag}, 8'h00);
        check("pulses", 8'(n_ce * 16 + n_rst), 8'h31);
        report_and_stop();
    end
    initial begin
        #1000000;
        failures++;
        report_and_stop();
    end
endmodule // serial_flash_erase_id_otp_reset_tb
`default_nettype wire
